// File: rtl/umg_slot.sv
// Gateway constants and one outstanding-command slot with its supervision timer
package umg_pkg;
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned TMO_UNIT_MS = 10;
   localparam int unsigned TMO_UNIT_CYC = CLK_HZ / 1000 * TMO_UNIT_MS;
   localparam int unsigned TMO_DEFAULT_S = 10;
   localparam logic [15:0] TMO_DEFAULT_UNITS = 16'(TMO_DEFAULT_S * 1000 / TMO_UNIT_MS);
   localparam logic [15:0] UDP_PORT = 16'hfa00;
   localparam int NSLOT = 4;
   // Command header byte offsets
   localparam logic [3:0] C_OFS_SEQ = 4'h0;
   localparam logic [3:0] C_OFS_TMO = 4'h2;
   localparam logic [3:0] C_OFS_SIZE = 4'h4;
   localparam logic [3:0] C_OFS_NODE = 4'h6;
   localparam logic [3:0] C_OFS_SVC = 4'h7;
   localparam logic [3:0] C_OFS_CLASS = 4'h8;
   localparam logic [3:0] C_OFS_INST = 4'ha;
   localparam logic [3:0] C_HDR_LAST = 4'hb;
   // Response header byte offsets
   localparam logic [2:0] R_OFS_SEQ = 3'h0;
   localparam logic [2:0] R_OFS_SIZE = 3'h2;
   localparam logic [2:0] R_OFS_NODE = 3'h4;
   localparam logic [2:0] R_OFS_SVC = 3'h5;
   // Size limits and service codes
   localparam logic [15:0] CMD_SIZE_MIN = 16'h0006;
   localparam logic [15:0] CMD_SIZE_MAX = 16'h01f2;
   localparam logic [15:0] RSP_SIZE_FIXED = 16'h0002;
   localparam logic [15:0] RSP_SIZE_MAX = 16'h01f2;
   localparam logic [8:0] ERR_PAY_LEN = 9'h002;
   localparam logic [7:0] SVC_OK_BIT = 8'h80;
   localparam logic [7:0] SVC_ERR = 8'h94;
   typedef enum {C_HDR, C_PAY, C_EMPTY, C_DROP} umg_cmd_st_t;
   typedef enum {R_IDLE, R_HDR, R_PAY, R_ERR, R_DROP} umg_rsp_st_t;
endpackage

`timescale 1ns/100ps
`default_nettype none
module umg_slot import umg_pkg::*; (
   input wire logic clk_sys, // System clock
   input wire logic rst, // Synchronous reset
   input wire logic load, // Take a new command
   input wire logic [15:0] ld_seq, // Command sequence
   input wire logic [15:0] ld_tmo, // Timeout field, 10 ms units
   input wire logic [7:0] ld_node, // Destination node
   input wire logic [7:0] ld_svc, // Requested service
   input wire logic [31:0] ld_ip, // Commanding host address
   input wire logic [15:0] ld_port, // Commanding host port
   input wire logic tick, // One pulse per timeout unit
   input wire logic free, // Response sent, release slot
   output logic busy, // Slot holds a command
   output logic expired, // Supervision time has run out
   output logic [15:0] seq, // Stored sequence
   output logic [7:0] node, // Stored node
   output logic [7:0] svc, // Stored service
   output logic [31:0] ip, // Stored host address
   output logic [15:0] port // Stored host port
);
   logic [15:0] limit_q;
   logic [15:0] elapsed_q;

   // Command context, kept for the response
   always_ff @(posedge clk_sys) begin
      if (load) begin
         seq <= ld_seq;
         node <= ld_node;
         svc <= ld_svc;
         ip <= ld_ip;
         port <= ld_port;
         limit_q <= (ld_tmo == 16'h0000) ? TMO_DEFAULT_UNITS : ld_tmo;
      end
   end

   // Occupancy
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         busy <= 1'b0;
      end else if (load) begin
         busy <= 1'b1;
      end else if (free) begin
         busy <= 1'b0;
      end
   end

   // Supervision timer counts shared tick pulses while waiting, so the first unit may be partial
   always_ff @(posedge clk_sys) begin
      if (rst || load || free) begin
         elapsed_q <= 16'h0000;
         expired <= 1'b0;
      end else if (busy && !expired && tick) begin
         elapsed_q <= elapsed_q + 16'h0001;
         expired <= (elapsed_q + 16'h0001 == limit_q);
      end
   end

   a_tmo_default: assert property (@(posedge clk_sys) disable iff (rst)
      (load && ld_tmo == 16'h0000) |=> (limit_q == TMO_DEFAULT_UNITS))
      else $error("zero timeout did not select default");
   a_expire_point: assert property (@(posedge clk_sys) disable iff (rst)
      $rose(expired) |-> (elapsed_q == limit_q && $past(tick)))
      else $error("slot expired at wrong count");
endmodule // umg_slot
`default_nettype wire

// File: rtl/umg_framer.sv
// UDP command to explicit request gateway framer, with response builder
// What this block does
// - Multi-byte fields travel least significant byte first
// - Response echoes command sequence number exactly
// - Timeout in 10 ms units, zero means 10 s
// - Service, class, instance forwarded to node unchanged
// - Every accepted command becomes an explicit request
// - Reply goes back to the commanding host
// - Response header: sequence, size, node, service, payload
// - Response size spans node to payload, 2-498
// - Response node is the commanded node
// - Success sets service top bit, failure 0x94
// - Error payload: general then additional code
// - Frames use fixed device UDP port 64000
// - Server only, up to four outstanding commands
`timescale 1ns/100ps
`default_nettype none
module umg_framer import umg_pkg::*; #(
   parameter int unsigned TICK_CYCLES = TMO_UNIT_CYC, // Cycles per timeout unit
   parameter logic [7:0] GEN_ERR_TMO = 8'h02, // General code on device timeout
   parameter logic [7:0] ADD_ERR_TMO = 8'hff // Additional code on device timeout
) (
   input wire logic clk_sys, // System clock
   input wire logic rst, // Synchronous reset
   input wire logic rx_valid, // Datagram byte valid
   input wire logic [7:0] rx_data, // Datagram byte
   input wire logic rx_last, // Last byte of datagram
   output logic rx_ready, // Byte accepted
   input wire logic [31:0] rx_src_ip, // Sender address
   input wire logic [15:0] rx_src_port, // Sender port
   input wire logic [15:0] rx_dst_port, // Destination port
   output logic req_valid, // Request beat valid
   input wire logic req_ready, // Node side accepts beat
   output logic [7:0] req_data, // Request payload byte
   output logic req_first, // First beat of request
   output logic req_last, // Last beat of request
   output logic req_empty, // Request carries no payload
   output logic req_abort, // Request cancelled, ignore it
   output logic [7:0] req_node, // Destination node
   output logic [7:0] req_service, // Service code
   output logic [15:0] req_class, // Class identifier
   output logic [15:0] req_instance, // Instance identifier
   output logic [1:0] req_slot, // Slot tag, returned with reply
   input wire logic rsp_valid, // Reply beat valid
   output logic rsp_ready, // Reply beat accepted
   input wire logic [7:0] rsp_data, // Reply payload byte
   input wire logic rsp_last, // Last reply beat
   input wire logic [1:0] rsp_slot, // Slot tag of reply
   input wire logic rsp_ok, // Reply is a success
   input wire logic [8:0] rsp_len, // Reply payload length
   output logic tx_valid, // Response byte valid
   input wire logic tx_ready, // Response byte accepted
   output logic [7:0] tx_data, // Response byte
   output logic tx_last, // Last response byte
   output logic [31:0] tx_dst_ip, // Host address
   output logic [15:0] tx_dst_port, // Host port
   output logic [15:0] tx_src_port, // Device port
   output logic [3:0] busy_slots // Outstanding commands
);
   localparam int TW = $clog2(TICK_CYCLES + 1);

   umg_cmd_st_t c_st;
   umg_rsp_st_t r_st;
   logic [7:0] hdr_q [12];
   logic [3:0] cnt_q;
   logic [8:0] pay_len_q;
   logic [8:0] pay_cnt_q;
   logic [31:0] host_ip_q;
   logic [15:0] host_port_q;
   logic [1:0] free_idx;
   logic [TW-1:0] tick_cnt_q;
   logic tick;
   logic [3:0] expired;
   logic [15:0] s_seq [NSLOT];
   logic [7:0] s_node [NSLOT];
   logic [7:0] s_svc [NSLOT];
   logic [31:0] s_ip [NSLOT];
   logic [15:0] s_port [NSLOT];
   logic rx_beat;
   logic hdr_done;
   logic [15:0] cmd_size;
   logic size_ok;
   logic end_beat;
   logic load;
   logic [3:0] free_vec;
   logic [1:0] rsel_q;
   logic rok_q;
   logic rtmo_q;
   logic [8:0] rlen_q;
   logic [2:0] rc_q;
   logic [8:0] rpay_q;
   logic [15:0] rsp_size;
   logic [7:0] svc_out;

   // Little-endian pair to word
   function automatic logic [15:0] le16(input logic [7:0] lo, input logic [7:0] hi);
      le16 = {hi, lo};
   endfunction

   // Lowest index with a set bit
   function automatic logic [1:0] lowest(input logic [3:0] v);
      lowest = 2'h0;
      for (int i = NSLOT - 1; i >= 0; i--) begin
         if (v[i]) begin
            lowest = 2'(i);
         end
      end
   endfunction

   // Timeout unit tick
   always_ff @(posedge clk_sys) begin
      if (rst || tick) begin
         tick_cnt_q <= '0;
      end else begin
         tick_cnt_q <= tick_cnt_q + TW'(1);
      end
   end
   assign tick = (tick_cnt_q == TW'(TICK_CYCLES - 1));

   // Command decode
   assign rx_beat = rx_valid && rx_ready;
   assign hdr_done = (c_st == C_HDR) && rx_beat && (cnt_q == C_HDR_LAST);
   assign cmd_size = le16(hdr_q[C_OFS_SIZE], hdr_q[C_OFS_SIZE + 4'h1]);
   assign size_ok = (rx_dst_port == UDP_PORT) && (cmd_size >= CMD_SIZE_MIN)
      && (cmd_size <= CMD_SIZE_MAX);
   assign end_beat = (pay_cnt_q == pay_len_q - 9'h001);
   assign free_idx = lowest(~busy_slots);
   assign load = ((c_st == C_PAY) && rx_beat && rx_last && end_beat)
      || ((c_st == C_EMPTY) && req_ready);

   // Header capture, one byte per offset
   always_ff @(posedge clk_sys) begin
      if (c_st == C_HDR && rx_beat) begin
         hdr_q[cnt_q] <= rx_data;
         if (cnt_q == C_OFS_SEQ) begin
            host_ip_q <= rx_src_ip;
            host_port_q <= rx_src_port;
         end
      end
      if (hdr_done) begin
         pay_len_q <= 9'(cmd_size - CMD_SIZE_MIN);
         req_slot <= free_idx;
      end
   end

   // Command parser; a slot must be free before bytes are taken
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         c_st <= C_HDR;
         cnt_q <= 4'h0;
         pay_cnt_q <= 9'h000;
      end else begin
         unique case (c_st)
            C_HDR: begin
               if (rx_beat) begin
                  cnt_q <= rx_last ? 4'h0 : cnt_q + 4'h1;
                  pay_cnt_q <= 9'h000;
                  if (hdr_done && !rx_last) begin
                     cnt_q <= 4'h0;
                     c_st <= (size_ok && cmd_size != CMD_SIZE_MIN) ? C_PAY : C_DROP;
                  end else if (hdr_done && size_ok && cmd_size == CMD_SIZE_MIN) begin
                     c_st <= C_EMPTY;
                  end
               end
            end
            C_PAY: begin
               if (rx_beat) begin
                  pay_cnt_q <= pay_cnt_q + 9'h001;
                  if (rx_last) begin
                     c_st <= C_HDR;
                  end else if (end_beat) begin
                     c_st <= C_DROP;
                  end
               end
            end
            C_EMPTY: begin
               if (req_ready) begin
                  c_st <= C_HDR;
               end
            end
            C_DROP: begin
               if (rx_valid && rx_last) begin
                  c_st <= C_HDR;
               end
            end
         endcase
      end
   end

   // Request channel: payload streams straight through
   always_comb begin
      rx_ready = 1'b0;
      req_valid = 1'b0;
      req_first = 1'b0;
      req_last = 1'b0;
      req_empty = 1'b0;
      req_abort = 1'b0;
      unique case (c_st)
         C_HDR: rx_ready = !(&busy_slots);
         C_PAY: begin
            rx_ready = req_ready;
            req_valid = rx_valid;
            req_first = (pay_cnt_q == 9'h000);
            req_last = rx_last || end_beat;
            req_abort = rx_last ^ end_beat;
         end
         C_EMPTY: begin
            req_valid = 1'b1;
            req_first = 1'b1;
            req_last = 1'b1;
            req_empty = 1'b1;
         end
         C_DROP: rx_ready = 1'b1;
      endcase
   end
   assign req_data = rx_data;
   assign req_node = hdr_q[C_OFS_NODE];
   assign req_service = hdr_q[C_OFS_SVC];
   assign req_class = le16(hdr_q[C_OFS_CLASS], hdr_q[C_OFS_CLASS + 4'h1]);
   assign req_instance = le16(hdr_q[C_OFS_INST], hdr_q[C_OFS_INST + 4'h1]);

   // Four message buffers
   for (genvar g = 0; g < NSLOT; g++) begin : g_slot
      umg_slot u_slot (
         .clk_sys(clk_sys),
         .rst(rst),
         .load(load && req_slot == 2'(g)),
         .ld_seq(le16(hdr_q[C_OFS_SEQ], hdr_q[C_OFS_SEQ + 4'h1])),
         .ld_tmo(le16(hdr_q[C_OFS_TMO], hdr_q[C_OFS_TMO + 4'h1])),
         .ld_node(hdr_q[C_OFS_NODE]),
         .ld_svc(hdr_q[C_OFS_SVC]),
         .ld_ip(host_ip_q),
         .ld_port(host_port_q),
         .tick(tick),
         .free(free_vec[g]),
         .busy(busy_slots[g]),
         .expired(expired[g]),
         .seq(s_seq[g]),
         .node(s_node[g]),
         .svc(s_svc[g]),
         .ip(s_ip[g]),
         .port(s_port[g])
      );
   end

   // Response builder; a device timeout takes precedence over replies
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         r_st <= R_IDLE;
         rc_q <= 3'h0;
         rpay_q <= 9'h000;
         rsel_q <= 2'h0;
         rok_q <= 1'b0;
         rtmo_q <= 1'b0;
         rlen_q <= 9'h000;
      end else begin
         unique case (r_st)
            R_IDLE: begin
               rc_q <= 3'h0;
               rpay_q <= 9'h000;
               if (|expired) begin
                  rsel_q <= lowest(expired);
                  rtmo_q <= 1'b1;
                  rok_q <= 1'b0;
                  rlen_q <= ERR_PAY_LEN;
                  r_st <= R_HDR;
               end else if (rsp_valid) begin
                  rsel_q <= rsp_slot;
                  rtmo_q <= 1'b0;
                  rok_q <= rsp_ok;
                  rlen_q <= rsp_len;
                  r_st <= busy_slots[rsp_slot] ? R_HDR : R_DROP;
               end
            end
            R_HDR: begin
               if (tx_ready) begin
                  rc_q <= rc_q + 3'h1;
                  if (rc_q == R_OFS_SVC) begin
                     r_st <= rtmo_q ? R_ERR : ((rlen_q == 9'h000) ? R_IDLE : R_PAY);
                  end
               end
            end
            R_PAY: begin
               if (rsp_valid && tx_ready) begin
                  rpay_q <= rpay_q + 9'h001;
                  if (rsp_last) begin
                     r_st <= R_IDLE;
                  end
               end
            end
            R_ERR: begin
               if (tx_ready) begin
                  rpay_q <= rpay_q + 9'h001;
                  if (rpay_q != 9'h000) begin
                     r_st <= R_IDLE;
                  end
               end
            end
            R_DROP: begin
               if (rsp_valid && rsp_last) begin
                  r_st <= R_IDLE;
               end
            end
         endcase
      end
   end

   // Response header fields
   assign rsp_size = RSP_SIZE_FIXED + {7'h00, rlen_q};
   assign svc_out = (rok_q && !rtmo_q) ? (s_svc[rsel_q] | SVC_OK_BIT) : SVC_ERR;

   // Response byte stream
   always_comb begin
      tx_valid = 1'b0;
      tx_data = 8'h00;
      tx_last = 1'b0;
      rsp_ready = 1'b0;
      free_vec = 4'h0;
      unique case (r_st)
         R_IDLE: ;
         R_HDR: begin
            tx_valid = 1'b1;
            unique case (rc_q)
               R_OFS_SEQ: tx_data = s_seq[rsel_q][7:0];
               R_OFS_SEQ + 3'h1: tx_data = s_seq[rsel_q][15:8];
               R_OFS_SIZE: tx_data = rsp_size[7:0];
               R_OFS_SIZE + 3'h1: tx_data = rsp_size[15:8];
               R_OFS_NODE: tx_data = s_node[rsel_q];
               default: tx_data = svc_out;
            endcase
            tx_last = (rc_q == R_OFS_SVC) && !rtmo_q && (rlen_q == 9'h000);
         end
         R_PAY: begin
            tx_valid = rsp_valid;
            tx_data = rsp_data;
            tx_last = rsp_last;
            rsp_ready = tx_ready;
         end
         R_ERR: begin
            tx_valid = 1'b1;
            tx_data = (rpay_q == 9'h000) ? GEN_ERR_TMO : ADD_ERR_TMO;
            tx_last = (rpay_q != 9'h000);
         end
         R_DROP: rsp_ready = 1'b1;
      endcase
      if (tx_valid && tx_ready && tx_last) begin
         free_vec[rsel_q] = 1'b1;
      end
   end
   assign tx_dst_ip = s_ip[rsel_q];
   assign tx_dst_port = s_port[rsel_q];
   assign tx_src_port = UDP_PORT;

   sequence s_err_gen;
      (r_st == R_ERR && rpay_q == 9'h000 && tx_valid);
   endsequence
   sequence s_seq_lo;
      (r_st == R_HDR && rc_q == R_OFS_SEQ && tx_valid && tx_ready);
   endsequence

   a_seq_echo: assert property (@(posedge clk_sys) disable iff (rst)
      s_seq_lo |-> (tx_data == s_seq[rsel_q][7:0]) ##1 (tx_data == s_seq[rsel_q][15:8]))
      else $error("sequence not echoed low byte first");
   a_svc_ok: assert property (@(posedge clk_sys) disable iff (rst)
      (r_st == R_HDR && rc_q == R_OFS_SVC && rok_q && !rtmo_q) |-> (tx_data == (s_svc[rsel_q] | SVC_OK_BIT)))
      else $error("success service byte wrong");
   a_svc_err: assert property (@(posedge clk_sys) disable iff (rst)
      (r_st == R_HDR && rc_q == R_OFS_SVC && rtmo_q) |-> (tx_data == SVC_ERR))
      else $error("error service byte wrong");
   a_err_payload: assert property (@(posedge clk_sys) disable iff (rst)
      (s_err_gen ##0 tx_ready) |-> (tx_data == GEN_ERR_TMO) ##1 (tx_data == ADD_ERR_TMO && tx_last))
      else $error("error payload order wrong");
   a_size_range: assert property (@(posedge clk_sys) disable iff (rst)
      (r_st == R_HDR && rc_q == R_OFS_SIZE) |-> (rsp_size >= RSP_SIZE_FIXED && rsp_size <= RSP_SIZE_MAX))
      else $error("response size out of range");
   a_bad_size_drop: assert property (@(posedge clk_sys) disable iff (rst)
      (hdr_done && !size_ok) |=> !req_valid [*2])
      else $error("bad size command forwarded");
   a_fwd_inst: assert property (@(posedge clk_sys) disable iff (rst)
      hdr_done |=> (req_instance[15:8] == $past(rx_data)))
      else $error("instance not forwarded unchanged");
   a_slots_full: assert property (@(posedge clk_sys) disable iff (rst)
      (c_st == C_HDR && (&busy_slots)) |-> !rx_ready)
      else $error("command taken with no free buffer");
endmodule // umg_framer
`default_nettype wire

// File: testbench/umg_host_model.sv
// Behavioural Ethernet host: sends command datagrams, takes responses with stalls
`timescale 1ns/100ps
`default_nettype none
module umg_host_model #(
   parameter logic [31:0] HOST_IP = 32'h0a000002, // Arbitrary host address
   parameter logic [15:0] HOST_PORT = 16'h1234 // Arbitrary host port
) (
   input wire logic clk_sys, // System clock
   output logic rx_valid, // Datagram byte valid
   output logic [7:0] rx_data, // Datagram byte
   output logic rx_last, // Last byte of datagram
   input wire logic rx_ready, // Byte taken by the device
   output logic [31:0] rx_src_ip, // Our address
   output logic [15:0] rx_src_port, // Our port
   output logic [15:0] rx_dst_port, // Device port
   output logic tx_ready // Response byte taken
);
   integer seed = 32'hf441;
   logic [15:0] dport = 16'hfa00;
   // Idle lines at time zero
   initial begin
      rx_valid = 1'b0;
      rx_data = 8'ha5;
      rx_last = 1'b0;
      rx_src_ip = HOST_IP;
      rx_src_port = HOST_PORT;
      rx_dst_port = 16'hfa00;
   end
   // Random stalls on responses; the host never gives up first
   always @(posedge clk_sys) tx_ready <= #1 (($random(seed) & 3) != 0);
   // Send one datagram, holding each byte until taken; junk data between frames
   task automatic send(input logic [7:0] b[$]);
      @(posedge clk_sys);
      #1;
      for (int i = 0; i < b.size(); i++) begin
         rx_valid <= 1'b1;
         rx_data <= b[i];
         rx_last <= (i == b.size() - 1);
         rx_dst_port <= dport;
         do @(posedge clk_sys); while (rx_ready !== 1'b1);
         #1;
      end
      rx_valid <= 1'b0;
      rx_last <= 1'b0;
      rx_data <= ~rx_data;
   endtask
endmodule // umg_host_model
`default_nettype wire

// File: testbench/udp_message_gateway_framer_tb_top.sv
// Self-checking bench for the UDP message gateway framer
`timescale 1ns/100ps
`default_nettype none
module udp_message_gateway_framer_tb_top;
   import umg_pkg::*;
   localparam logic [31:0] HIP = 32'h0a000002; // Arbitrary host address
   localparam logic [15:0] HPORT = 16'h1234; // Arbitrary host port
   logic clk_sys, rst, rx_valid, rx_last, rx_ready, req_valid, req_ready, req_first, req_last, req_empty, req_abort;
   logic rsp_valid, rsp_ready, rsp_last, rsp_ok, tx_valid, tx_ready, tx_last;
   logic [7:0] rx_data, req_data, req_node, req_service, rsp_data, tx_data, e_node, e_svc;
   logic [15:0] rx_src_port, rx_dst_port, req_class, req_instance, tx_dst_port, tx_src_port, e_cls, e_inst;
   logic [31:0] rx_src_ip, tx_dst_ip;
   logic [1:0] req_slot, rsp_slot, last_slot;
   logic [8:0] rsp_len;
   logic [3:0] busy_slots;
   logic [11:0] e_req;
   logic [11:0] exp_req[$];
   logic [8:0] exp_tx[$];
   logic [33:0] pend[$];
   integer seed = 32'hf441;
   int n_fail = 0;
   int checks_done = 0;
   // Clock
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   umg_framer #(.TICK_CYCLES(10), .GEN_ERR_TMO(8'h02), .ADD_ERR_TMO(8'hff)) dut_u (
      .clk_sys(clk_sys), .rst(rst), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last), .rx_ready(rx_ready),
      .rx_src_ip(rx_src_ip), .rx_src_port(rx_src_port), .rx_dst_port(rx_dst_port), .req_valid(req_valid),
      .req_ready(req_ready), .req_data(req_data), .req_first(req_first), .req_last(req_last), .req_empty(req_empty),
      .req_abort(req_abort), .req_node(req_node), .req_service(req_service), .req_class(req_class),
      .req_instance(req_instance), .req_slot(req_slot), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
      .rsp_data(rsp_data), .rsp_last(rsp_last), .rsp_slot(rsp_slot), .rsp_ok(rsp_ok), .rsp_len(rsp_len),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last), .tx_dst_ip(tx_dst_ip),
      .tx_dst_port(tx_dst_port), .tx_src_port(tx_src_port), .busy_slots(busy_slots));
   umg_host_model #(.HOST_IP(HIP), .HOST_PORT(HPORT)) host_u (
      .clk_sys(clk_sys), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last), .rx_ready(rx_ready),
      .rx_src_ip(rx_src_ip), .rx_src_port(rx_src_port), .rx_dst_port(rx_dst_port), .tx_ready(tx_ready));
   // Compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic ex(input logic [7:0] v, input logic l);
      exp_tx.push_back({l, v});
   endtask
   // Wait, bounded, until every noted response byte has been seen
   task automatic wait_tx;
      for (int i = 0; i < 3000 && exp_tx.size() > 0; i++) @(posedge clk_sys);
      repeat (2) @(posedge clk_sys);
      #1;
      chk(32'(exp_tx.size()), 32'h0);
   endtask
   // Note the response header for pending command k, low byte first
   task automatic exp_hdr(input int k, input logic [7:0] svc, input logic [15:0] sz);
      ex(pend[k][23:16], 1'b0);
      ex(pend[k][31:24], 1'b0);
      ex(sz[7:0], 1'b0);
      ex(sz[15:8], 1'b0);
      ex(pend[k][15:8], 1'b0);
      ex(svc, sz == 16'h0002);
   endtask
   // Build and send one command; note request beats only when its header should be accepted (good set)
   task automatic cmd(input logic [15:0] seq, input logic [15:0] tmo, input logic [15:0] size, input int npay,
                      input logic good);
      logic [7:0] b[$];
      logic [7:0] d;
      logic lst;
      int np;
      np = int'(size) - 6;
      e_node = {2'b00, 6'($random(seed))};
      e_svc = {1'b0, 7'($random(seed))};
      e_cls = 16'($random(seed));
      e_inst = 16'($random(seed));
      b = {seq[7:0], seq[15:8], tmo[7:0], tmo[15:8], size[7:0], size[15:8], e_node, e_svc,
           e_cls[7:0], e_cls[15:8], e_inst[7:0], e_inst[15:8]};
      for (int i = 0; i < npay; i++) begin
         d = 8'($random(seed));
         b.push_back(d);
         lst = (i == npay - 1) || (i == np - 1);
         if (good && i < np) exp_req.push_back({lst && npay != np, i == 0, 1'b0, lst, d});
      end
      if (good && npay == 0) exp_req.push_back(12'h700);
      host_u.send(b);
      for (int i = 0; i < 200 && exp_req.size() > 0; i++) @(posedge clk_sys);
      #1;
      chk(32'(exp_req.size()), 32'h0);
      if (good && npay == np) pend.push_back({last_slot, seq, e_node, e_svc});
   endtask
   // Node reply for pending command k, beats held until taken
   task automatic reply(input int k, input logic ok, input int len);
      logic [7:0] d;
      exp_hdr(k, ok ? (pend[k][7:0] | 8'h80) : 8'h94, 16'(2 + len));
      for (int i = 0; i < len; i++) begin
         d = 8'($random(seed));
         ex(d, i == len - 1);
         rsp_valid <= 1'b1;
         rsp_data <= d;
         rsp_last <= (i == len - 1);
         rsp_slot <= pend[k][33:32];
         rsp_ok <= ok;
         rsp_len <= 9'(len);
         do @(posedge clk_sys); while (rsp_ready !== 1'b1);
         #1;
      end
      rsp_valid <= 1'b0;
      rsp_data <= ~d;
      pend.delete(k);
      wait_tx();
   endtask
   // Device supervision error response for the oldest pending command
   task automatic exp_err;
      exp_hdr(0, 8'h94, 16'h0004);
      ex(8'h02, 1'b0);
      ex(8'hff, 1'b1);
      pend.delete(0);
      wait_tx();
   endtask
   // Node side stalls at random
   always @(posedge clk_sys) req_ready <= #1 (($random(seed) & 3) != 0);
   // Request watcher takes the oldest note on each beat
   always @(posedge clk_sys) begin
      if (req_valid === 1'b1 && req_ready === 1'b1) begin
         if (exp_req.size() == 0) chk(32'(req_valid), 32'h0);
         else begin
            e_req = exp_req.pop_front();
            chk(32'({req_abort, req_first, req_empty, req_last}), 32'(e_req[11:8]));
            if (!e_req[9]) chk(32'(req_data), 32'(e_req[7:0]));
            chk({req_node, req_service, req_class}, {e_node, e_svc, e_cls});
            chk(32'(req_instance), 32'(e_inst));
            last_slot = req_slot;
         end
      end
   end
   // Response watcher takes the oldest note on each byte
   always @(posedge clk_sys) begin
      if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
         if (exp_tx.size() == 0) chk(32'(tx_valid), 32'h0);
         else chk(32'({tx_last, tx_data}), 32'(exp_tx.pop_front()));
         chk(tx_dst_ip, HIP);
         chk({tx_dst_port, tx_src_port}, {HPORT, 16'hfa00});
      end
   end
   // Watchdog
   initial begin
      #(40000 * 10);
      n_fail++;
      tally_and_finish();
   end
   // Main sequence
   initial begin
      rst = 1'b1;
      rsp_valid = 1'b0;
      rsp_data = 8'h00;
      rsp_last = 1'b0;
      rsp_slot = 2'h0;
      rsp_ok = 1'b0;
      rsp_len = 9'h000;
      repeat (3) @(posedge clk_sys);
      #1;
      rst = 1'b0;
      chk(32'(busy_slots), 32'h0);
      cmd(16'hbeef, 16'h0100, 16'h0009, 3, 1'b1);
      reply(0, 1'b1, 2);
      cmd(16'hffff, 16'h0100, 16'h0006, 0, 1'b1);
      reply(0, 1'b1, 1);
      cmd(16'h0000, 16'h0100, 16'h01f2, 492, 1'b1);
      reply(0, 1'b1, 496);
      $display("test sizes done");
      for (int k = 0; k < 4; k++) cmd(16'($random(seed)), 16'h0100, 16'h0008, 2, 1'b1);
      chk(32'(busy_slots), 32'hf);
      for (int k = 3; k >= 0; k--) reply(k, k[0], 2);
      chk(32'(busy_slots), 32'h0);
      $display("test four outstanding done");
      cmd(16'h0001, 16'h0100, 16'h0005, 0, 1'b0);
      cmd(16'h0002, 16'h0100, 16'h01f3, 493, 1'b0);
      host_u.dport = 16'hfa01;
      cmd(16'h0003, 16'h0100, 16'h0008, 2, 1'b0);
      host_u.dport = 16'hfa00;
      // Size fits but datagram too long, then too short: streamed beats end aborted
      cmd(16'h0004, 16'h0100, 16'h0008, 3, 1'b1);
      cmd(16'h0005, 16'h0100, 16'h0008, 1, 1'b1);
      chk(32'(busy_slots), 32'h0);
      $display("test refused done");
      cmd(16'h0a0b, 16'h0003, 16'h0007, 1, 1'b1);
      exp_err();
      cmd(16'h0c0d, 16'h0000, 16'h0007, 1, 1'b1);
      repeat (9800) @(posedge clk_sys);
      chk(32'(busy_slots != 4'h0), 32'h1);
      exp_err();
      $display("test supervision done");
      tally_and_finish();
   end
endmodule // udp_message_gateway_framer_tb_top
`default_nettype wire
